// *** standby_defines.svh ***
// Shared offsets, field positions, reset values and timing counts of the standby controller
`ifndef STANDBY_DEFINES_SVH
`define STANDBY_DEFINES_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ           125
`define STAB_BASE_CYCLES  16
`define REF_SETTLE_US     300
`define OSC_SETTLE_US     50
`define SETTLE_CYCLES     ((`REF_SETTLE_US + `OSC_SETTLE_US) * `CLK_MHZ)
`define SETTLE_NOPS       85
`define LS_MAX_KHZ        480
`define STS_RESET         3'h5
// ----------------------------------------
// Peripheral gate indexes
// ----------------------------------------
`define PG_TIMER_A        0
`define PG_SERIAL         1
`define PG_WDT            2
`define PG_HIZ            3
`define PG_POC            4
`define PG_LVD            5
`define PG_EXTINT         6
`define PG_INV_TIMER      7
`define PG_TIMER16        8
`define PG_TIMER_B        9
`define PG_RTPORT         10
`define PG_ADC            11
`define PG_MULDIV         12
`define PG_COUNT          13
// ----------------------------------------
// Register offsets of the controller
// ----------------------------------------
`define OFS_CTRL          8'h00
`define OFS_IRQ           8'h04
`define OFS_CFG           8'h08
`define OFS_STAT          8'h0C
`define OFS_PORT          8'h10
// CTRL bits
`define CTRL_HALT         0
`define CTRL_STOP         1
`define CTRL_RESET        2
`define CTRL_CLR          3
// IRQ bits
`define IRQ_FLAG          0
`define IRQ_MASK          1
`define IRQ_PRIO          2
`define IRQ_IE            3
`define IRQ_ISP           4
// CFG bits
`define CFG_STS_LSB       0
`define CFG_LS_STOP       3
`define CFG_LS_STOPPABLE  4
`define CFG_ON_LOWSPEED   5
`define CFG_HS_INT_RUN    6
`define CFG_TA_EXT        7
`define CFG_SER_TB        8
`define CFG_TB_RUN        9
`define CFG_MAIN_SEL      10
`define CFG_EXT_CLK       11
`endif

// *** standby_pkg.sv ***
// Types shared by both ends of the standby link
package standby_pkg;
  // One-hot standby states
  typedef enum logic [3:0] {
    ST_RUN  = 4'h1,
    ST_HALT = 4'h2,
    ST_STOP = 4'h4,
    ST_WAIT = 4'h8
  } standby_state_e;
endpackage

// *** standby_if.sv ***
// Link between the CPU/interrupt side and the standby controller
`timescale 1ns/1ns
interface standby_if;
  logic        halt_exec;                 // HALT instruction, pulse
  logic        stop_exec;                 // STOP instruction, pulse
  logic        reset_in;                  // Reset input, pulse
  logic        irq_flag;                  // Pending request flag
  logic        interrupt_mask_flag;
  logic        interrupt_priority_flag;
  logic        global_interrupt_enable;
  logic        in_service_priority_flag;
  logic [2:0]  stabilization_time_select;
  logic        lowspeed_osc_stop_bit;
  logic        ls_stoppable;              // Option: with the low-speed osc stop bit, WDT is gated in STOP
  logic        timer_a_ext_sel;           // Timer A counts its external input
  logic        serial_from_timer_b;       // Serial clock is timer B output
  logic        timer_b_running;
  logic [3:0]  mode;                      // standby_state_e code
  logic        wake;                      // Release pulse
  logic        wake_vector;               // With wake: 1 vector, 0 next instr
  logic        reset_seq;                 // Reset processing pulse
  logic        cpu_clk_en;
  logic        x1_osc_en;
  logic        hs_osc_en;
  logic        ls_osc_en;
  logic        stabilization_counter_status;
  logic        port_hold;                 // Port latches frozen
  logic [12:0] periph_en;
  modport dev (input halt_exec, stop_exec, reset_in, irq_flag, interrupt_mask_flag,
               interrupt_priority_flag, global_interrupt_enable, in_service_priority_flag,
               stabilization_time_select, lowspeed_osc_stop_bit, ls_stoppable,
               timer_a_ext_sel, serial_from_timer_b, timer_b_running,
               output mode, wake, wake_vector, reset_seq, cpu_clk_en, x1_osc_en, hs_osc_en,
               ls_osc_en, stabilization_counter_status, port_hold, periph_en);
  modport cpu (output halt_exec, stop_exec, reset_in, irq_flag, interrupt_mask_flag,
               interrupt_priority_flag, global_interrupt_enable, in_service_priority_flag,
               stabilization_time_select, lowspeed_osc_stop_bit, ls_stoppable,
               timer_a_ext_sel, serial_from_timer_b, timer_b_running,
               input mode, wake, wake_vector, reset_seq, cpu_clk_en, x1_osc_en, hs_osc_en,
               ls_osc_en, stabilization_counter_status, port_hold, periph_en);
endinterface

// *** standby_ctrl.sv ***
// Standby controller: HALT/STOP entry, release, oscillator and peripheral gating
`timescale 1ns/1ns
`include "standby_defines.svh"

module standby_ctrl
  import standby_pkg::*;
#(
  parameter int STAB_BASE = `STAB_BASE_CYCLES,  // Stabilization cycles for select code 0
  parameter int CW        = 16                  // Stabilization counter width
) (
  input wire logic aclk,
  input wire logic aresetn,
  standby_if.dev   sb
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  standby_state_e state_reg;            // Current standby state
  logic           from_stop_reg;        // WAIT was reached from STOP
  logic           reset_pend_reg;       // Reset seen during STOP or its wait
  logic           vector_reg;           // Wake decision captured on release
  logic [CW-1:0]  cnt_reg;              // Stabilization down-counter
  logic           stab_done_reg;        // Counter status flag
  logic           ls_hold_reg;          // Low-speed oscillator stop, frozen in STOP
  logic           wake_reg;             // Release pulse
  logic           wake_vec_reg;         // Release kind
  logic           reset_seq_reg;        // Reset processing pulse
  logic           unmasked;             // A request is pending and unmasked
  logic           vector_ok;            // Release would vector
  logic           stop_like;            // Peripherals in STOP gating
  logic           cnt_done;             // Stabilization wait over
  logic [12:0]    keep;                 // Peripherals that survive STOP

  // Wait length grows in powers of two with the select code
  function automatic logic [CW-1:0] stab_cycles(input logic [2:0] sel);
    logic [CW-1:0] base;
    base        = CW'(STAB_BASE);
    stab_cycles = base << sel;
  endfunction

  // ----------------------------------------
  // Release decision
  // ----------------------------------------
  // Besides the reset input, only an unmasked pending request can release a standby state
  assign unmasked  = sb.irq_flag & ~sb.interrupt_mask_flag;
  // Low priority vectors with enable; high priority also needs in-service flag
  assign vector_ok = sb.global_interrupt_enable &
                     (~sb.interrupt_priority_flag | sb.in_service_priority_flag);
  assign cnt_done  = (state_reg == ST_WAIT) && (cnt_reg == '0);

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  // Reset input outranks any interrupt release, except a reset in the last WAIT cycle, which is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_RUN;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (sb.reset_in) begin
            state_reg <= ST_RUN;
          end else if (sb.stop_exec) begin
            // Clock source is checked on the CPU side, which drops STOP while the internal high-speed clock runs the CPU
            state_reg <= unmasked ? ST_WAIT : ST_STOP;
          end else if (sb.halt_exec) begin
            state_reg <= ST_HALT;
          end
        end
        ST_HALT: begin
          // Masked requests leave the core halted
          if (sb.reset_in || unmasked) begin
            state_reg <= ST_RUN;
          end
        end
        ST_STOP: begin
          // Either release source first restarts the oscillators
          if (sb.reset_in || unmasked) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cnt_done) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // Remember whether the wait belongs to a real STOP or a fallback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      from_stop_reg <= 1'b0;
    end else if (state_reg == ST_STOP) begin
      from_stop_reg <= 1'b1;
    end else if (state_reg == ST_RUN) begin
      from_stop_reg <= 1'b0;
    end
  end

  // A reset during STOP is held until the oscillator is stable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_pend_reg <= 1'b0;
    end else if (state_reg == ST_RUN) begin
      reset_pend_reg <= 1'b0;
    end else if (sb.reset_in && (state_reg != ST_HALT)) begin
      reset_pend_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Stabilization counter
  // ----------------------------------------
  // Loaded on entry to WAIT; select code sampled at that moment
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else if ((state_reg == ST_RUN && sb.stop_exec && !sb.reset_in && unmasked) ||
                 (state_reg == ST_STOP && (sb.reset_in || unmasked))) begin
      cnt_reg <= stab_cycles(sb.stabilization_time_select) - CW'(1);
    end else if (state_reg == ST_WAIT && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CW'(1);
    end
  end

  // Status flag: high once a wait has run out, low while waiting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stab_done_reg <= 1'b0;
    end else if (cnt_done) begin
      stab_done_reg <= 1'b1;
    end else if (state_reg == ST_WAIT) begin
      stab_done_reg <= 1'b0;
    end
  end

  // Wake kind is captured as the wait starts, as the request that released it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_reg <= 1'b0;
    end else if (state_reg != ST_WAIT) begin
      vector_reg <= vector_ok;
    end
  end

  // ----------------------------------------
  // Release pulses
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_reg     <= 1'b0;
      wake_vec_reg <= 1'b0;
    end else if (state_reg == ST_HALT && !sb.reset_in && unmasked) begin
      wake_reg     <= 1'b1;
      wake_vec_reg <= vector_ok;
    end else if (cnt_done && !reset_pend_reg) begin
      wake_reg     <= 1'b1;
      wake_vec_reg <= vector_reg;
    end else begin
      wake_reg     <= 1'b0;
      wake_vec_reg <= 1'b0;
    end
  end

  // Reset processing: at once when running or halted, after the wait from STOP
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_seq_reg <= 1'b0;
    end else begin
      reset_seq_reg <= (sb.reset_in && (state_reg == ST_RUN || state_reg == ST_HALT)) ||
                       (cnt_done && reset_pend_reg);
    end
  end

  // ----------------------------------------
  // Oscillators
  // ----------------------------------------
  // Stop bit is frozen in STOP so the low-speed clock cannot start or stop until STOP ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ls_hold_reg <= 1'b0;
    end else if (state_reg != ST_STOP) begin
      ls_hold_reg <= sb.lowspeed_osc_stop_bit;
    end
  end

  assign sb.x1_osc_en  = (state_reg != ST_STOP);
  assign sb.hs_osc_en  = (state_reg != ST_STOP);
  assign sb.ls_osc_en  = ~ls_hold_reg;
  assign sb.cpu_clk_en = (state_reg == ST_RUN);

  // ----------------------------------------
  // Peripheral gating
  // ----------------------------------------
  // The wait after STOP keeps STOP gating until the CPU runs again
  assign stop_like = (state_reg == ST_STOP) || (state_reg == ST_WAIT && from_stop_reg);

  always_comb begin
    keep                  = '0;
    keep[`PG_TIMER_A]     = sb.timer_a_ext_sel;
    keep[`PG_SERIAL]      = sb.serial_from_timer_b & sb.timer_b_running;
    keep[`PG_WDT]         = ~(sb.ls_stoppable & sb.lowspeed_osc_stop_bit);
    keep[`PG_HIZ]         = 1'b1;
    keep[`PG_POC]         = 1'b1;
    keep[`PG_LVD]         = 1'b1;
    keep[`PG_EXTINT]      = 1'b1;
  end

  // One gate per peripheral
  generate
    for (genvar i = 0; i < `PG_COUNT; i++) begin : g_gate
      assign sb.periph_en[i] = ~stop_like | keep[i];
    end
  endgenerate

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sb.port_hold                    = stop_like;
  assign sb.mode                         = state_reg;
  assign sb.wake                         = wake_reg;
  assign sb.wake_vector                  = wake_vec_reg;
  assign sb.reset_seq                    = reset_seq_reg;
  assign sb.stabilization_counter_status = stab_done_reg;

endmodule

// *** standby_cpu_side.sv ***
// CPU-side end: AXI4-Lite register file driving the standby link
`timescale 1ns/1ns
`include "standby_defines.svh"

module standby_cpu_side
  import standby_pkg::*;
#(
  parameter int SETTLE = `SETTLE_CYCLES   // Internal high-speed settling wait
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic [7:0]       port_out,      // Port output latches
  standby_if.cpu           sb
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0]  aw_reg;           // Captured write address
  logic        aw_got;
  logic [31:0] w_reg;            // Captured write data
  logic        w_got;
  logic        wstrb0_reg;       // Either of the two low byte lanes enabled
  logic [4:0]  irq_reg;          // Request, mask, priority, enable, in-service
  logic [11:0] cfg_reg;          // Configuration bits
  logic [7:0]  port_reg;         // Port latch value
  logic [2:0]  cmd_reg;          // One-cycle commands
  logic        refused_reg;      // STOP refused, sticky
  logic        woke_reg;         // Wake seen, sticky
  logic        last_vec_reg;     // Kind of the last wake
  logic [31:0] settle_reg;       // Settling countdown after reset
  logic        do_write;
  logic        hit_w;
  logic        hit_r;
  logic        stop_bad;

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  // Address and data may arrive in either order; the answer follows both
  assign s_awready = ~aw_got & ~s_bvalid;
  assign s_wready  = ~w_got & ~s_bvalid;
  assign do_write  = aw_got & w_got & ~s_bvalid;
  assign hit_w     = aw_reg == `OFS_CTRL || aw_reg == `OFS_IRQ || aw_reg == `OFS_CFG ||
                     aw_reg == `OFS_STAT || aw_reg == `OFS_PORT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      aw_reg <= 8'h00;
      w_got  <= 1'b0;
      w_reg  <= 32'h00000000;
      wstrb0_reg <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_got <= 1'b1;
        aw_reg <= s_awaddr;
      end else if (do_write) begin
        aw_got <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_got      <= 1'b1;
        w_reg      <= s_wdata;
        wstrb0_reg <= s_wstrb[0] | s_wstrb[1];
      end else if (do_write) begin
        w_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= 2'h0;
    end else if (do_write) begin
      s_bvalid <= 1'b1;
      s_bresp  <= hit_w ? 2'h0 : 2'h2;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Software may not STOP while the internal high-speed clock runs the CPU
  assign stop_bad = cfg_reg[`CFG_HS_INT_RUN] & ~cfg_reg[`CFG_ON_LOWSPEED];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_reg <= 3'h0;
    end else if (do_write && aw_reg == `OFS_CTRL && wstrb0_reg) begin
      cmd_reg[`CTRL_HALT]  <= w_reg[`CTRL_HALT];
      cmd_reg[`CTRL_STOP]  <= w_reg[`CTRL_STOP] & ~stop_bad;
      cmd_reg[`CTRL_RESET] <= w_reg[`CTRL_RESET];
    end else begin
      cmd_reg <= 3'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg  <= 5'h00;
      port_reg <= 8'h00;
    end else if (do_write && wstrb0_reg) begin
      if (aw_reg == `OFS_IRQ) begin
        irq_reg <= w_reg[4:0];
      end
      // Port writes are dropped while the latches are frozen
      if (aw_reg == `OFS_PORT && !sb.port_hold) begin
        port_reg <= w_reg[7:0];
      end
    end
  end

  // Main clock select is held back until the settling wait ends, unless the clock is external
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= {9'h000, `STS_RESET};
    end else if (do_write && aw_reg == `OFS_CFG && wstrb0_reg) begin
      cfg_reg[9:0]          <= w_reg[9:0];
      cfg_reg[`CFG_EXT_CLK] <= w_reg[`CFG_EXT_CLK];
      if (settle_reg == 32'h00000000 || w_reg[`CFG_EXT_CLK]) begin
        cfg_reg[`CFG_MAIN_SEL] <= w_reg[`CFG_MAIN_SEL];
      end
    end
  end

  // Stands in for the software NOP loop after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_reg <= 32'(SETTLE);
    end else if (settle_reg != 32'h00000000) begin
      settle_reg <= settle_reg - 32'h00000001;
    end
  end

  // Sticky status: hardware set wins over the software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused_reg  <= 1'b0;
      woke_reg     <= 1'b0;
      last_vec_reg <= 1'b0;
    end else begin
      if (do_write && aw_reg == `OFS_CTRL && w_reg[`CTRL_STOP] && stop_bad) begin
        refused_reg <= 1'b1;
      end else if (do_write && aw_reg == `OFS_CTRL && w_reg[`CTRL_CLR]) begin
        refused_reg <= 1'b0;
      end
      if (sb.wake) begin
        woke_reg     <= 1'b1;
        last_vec_reg <= sb.wake_vector;
      end else if (do_write && aw_reg == `OFS_CTRL && w_reg[`CTRL_CLR]) begin
        woke_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign s_arready = ~s_rvalid;
  assign hit_r     = s_araddr == `OFS_CTRL || s_araddr == `OFS_IRQ || s_araddr == `OFS_CFG ||
                     s_araddr == `OFS_STAT || s_araddr == `OFS_PORT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h00000000;
      s_rresp  <= 2'h0;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp  <= hit_r ? 2'h0 : 2'h2;
      unique case (s_araddr)
        `OFS_IRQ:  s_rdata <= {27'h0000000, irq_reg};
        `OFS_CFG:  s_rdata <= {20'h00000, cfg_reg};
        `OFS_STAT: s_rdata <= {sb.periph_en, 7'h00, sb.stabilization_counter_status, sb.ls_osc_en,
                               sb.hs_osc_en, sb.x1_osc_en, sb.cpu_clk_en, sb.mode,
                               last_vec_reg, woke_reg, refused_reg};
        `OFS_PORT: s_rdata <= {24'h000000, port_reg};
        default:   s_rdata <= 32'h00000000;
      endcase
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Link drive
  // ----------------------------------------
  assign sb.halt_exec                 = cmd_reg[`CTRL_HALT];
  assign sb.stop_exec                 = cmd_reg[`CTRL_STOP];
  assign sb.reset_in                  = cmd_reg[`CTRL_RESET];
  assign sb.irq_flag                  = irq_reg[`IRQ_FLAG];
  assign sb.interrupt_mask_flag       = irq_reg[`IRQ_MASK];
  assign sb.interrupt_priority_flag   = irq_reg[`IRQ_PRIO];
  assign sb.global_interrupt_enable   = irq_reg[`IRQ_IE];
  assign sb.in_service_priority_flag  = irq_reg[`IRQ_ISP];
  assign sb.stabilization_time_select = cfg_reg[2:0];
  assign sb.lowspeed_osc_stop_bit     = cfg_reg[`CFG_LS_STOP];
  assign sb.ls_stoppable              = cfg_reg[`CFG_LS_STOPPABLE];
  assign sb.timer_a_ext_sel           = cfg_reg[`CFG_TA_EXT];
  assign sb.serial_from_timer_b       = cfg_reg[`CFG_SER_TB];
  assign sb.timer_b_running           = cfg_reg[`CFG_TB_RUN];
  assign port_out                     = port_reg;

endmodule

// *** standby_monitor.sv ***
// Concurrent checks on the standby link
`timescale 1ns/1ns
module standby_monitor
  import standby_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        halt_exec,
  input wire logic        stop_exec,
  input wire logic        reset_in,
  input wire logic        irq_flag,
  input wire logic        interrupt_mask_flag,
  input wire logic [3:0]  mode,
  input wire logic        wake,
  input wire logic        reset_seq,
  input wire logic        cpu_clk_en,
  input wire logic        x1_osc_en,
  input wire logic        hs_osc_en,
  input wire logic        port_hold,
  input wire logic [12:0] periph_en
);
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire unm = irq_flag && !interrupt_mask_flag;  // Request able to release standby
  a_halt_entry: assert property (mode == ST_RUN && halt_exec && !stop_exec && !reset_in |=> mode == ST_HALT)
    else $error("halt not entered");
  a_halt_held: assert property (mode == ST_HALT && irq_flag && interrupt_mask_flag && !reset_in |=> mode == ST_HALT)
    else $error("masked request left halt");
  a_halt_wake: assert property (mode == ST_HALT && unm && !reset_in |=> wake && mode == ST_RUN)
    else $error("halt not released");
  a_stop_entry: assert property (mode == ST_RUN && stop_exec && !unm && !reset_in |=> mode == ST_STOP)
    else $error("stop not entered");
  a_stop_fallback: assert property (mode == ST_RUN && stop_exec && unm && !reset_in |=> mode == ST_WAIT)
    else $error("pending request did not fall back");
  a_stop_release: assert property (mode == ST_STOP && (unm || reset_in) |=> mode == ST_WAIT)
    else $error("stop not released");
  a_stop_clocks: assert property (mode == ST_STOP |-> !cpu_clk_en && !x1_osc_en && !hs_osc_en && port_hold)
    else $error("clocks or ports live in stop");
  a_stop_periph: assert property (mode == ST_STOP |-> periph_en[12:7] == 6'h00 && periph_en[6:3] == 4'hF)
    else $error("peripheral gates wrong in stop");
  a_reset_seq: assert property (mode == ST_RUN && reset_in |=> reset_seq)
    else $error("reset processing missing");
  cover property (mode == ST_STOP ##1 mode == ST_WAIT);
  cover property (wake);
  cover property (reset_seq);
endmodule

// *** tb.sv ***
// Self-checking bench for both ends of the standby link
`timescale 1ns/1ns
module tb
  import standby_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00, port_out, pv;
  logic [31:0] s_wdata = 32'h0, s_rdata, c;
  logic [3:0]  s_wstrb = 4'hF;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, v;
  logic [1:0]  s_bresp, s_rresp;
  logic [12:0] pe;
  logic [33:0] exp_q[$], msk_q[$], m;  // Expected read results and masks
  int          seed = 32'h2764633C, tests_run = 0, mismatches = 0;
  always #4 aclk = ~aclk;
  standby_if sb();
  standby_ctrl i_standby_ctrl (.aclk, .aresetn, .sb);
  standby_cpu_side #(.SETTLE(60)) i_standby_cpu_side (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .port_out, .sb);
  standby_monitor i_standby_monitor (.aclk, .aresetn, .halt_exec(sb.halt_exec), .stop_exec(sb.stop_exec),
    .reset_in(sb.reset_in), .irq_flag(sb.irq_flag), .interrupt_mask_flag(sb.interrupt_mask_flag),
    .mode(sb.mode), .wake(sb.wake), .reset_seq(sb.reset_seq), .cpu_clk_en(sb.cpu_clk_en),
    .x1_osc_en(sb.x1_osc_en), .hs_osc_en(sb.hs_osc_en), .port_hold(sb.port_hold), .periph_en(sb.periph_en));
  // ----------------
  // Bus tasks
  // ----------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    // Each channel is released at the edge that takes it
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while ((s_awvalid && !s_awready) || (s_wvalid && !s_wready));
    do @(posedge aclk); while (!s_bvalid);
    s_bready <= 1'b0;
  endtask
  // Note expectation first, the watcher compares when data arrives
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] k);
    exp_q.push_back(e);
    msk_q.push_back(k);
    @(posedge aclk);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'h3;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_rvalid);
    s_rready <= 1'b0;
  endtask
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    if (s_rvalid && s_rready) begin
      m = msk_q.pop_front();
      check({s_rresp, s_rdata} & m, exp_q.pop_front() & m);
    end
  end
  // ----------------
  // Sequence
  // ----------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h08, 34'h5, 34'h3FFFFFFFF);
    rd(8'h20, 34'h200000000, 34'h3FFFFFFFF);
    pv = 8'($random(seed));
    wr(8'h10, {24'h0, pv});
    wr(8'h08, 32'h405);
    rd(8'h08, 34'h5, 34'h3FFFFFFFF);
    wr(8'h08, 32'hC05);
    rd(8'h08, 34'hC05, 34'h3FFFFFFFF);
    for (int i = 0; i < 16; i++) begin
      v = i[2] && (!i[1] || i[3]);
      wr(8'h04, {27'h0, i[3:0], 1'b0});
      wr(8'h00, 32'h1);
      wr(8'h04, {27'h0, i[3:0], 1'b1});
      if (i[0]) rd(8'h0C, 34'h10, 34'h7A);
      else rd(8'h0C, {31'h1, v, 2'h2}, 34'h7E);
      wr(8'h04, 32'h1);
      wr(8'h00, 32'h8);
    end
    $display("halt table done");
    for (int j = 0; j < 2; j++) begin
      c = (32'($random(seed)) & 32'h398) | (j << 5);
      pe = {6'h00, 4'hF, !(c[4] && c[3]), c[8] && c[9], c[7]};
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h8);
      wr(8'h08, c);
      wr(8'h00, 32'h2);
      rd(8'h0C, {2'h0, pe, 8'h0, !c[3], 10'h020}, 34'h0FFF807F8);
      wr(8'h10, {24'h0, ~pv});
      rd(8'h10, {26'h0, pv}, 34'h3FFFFFFFF);
      check({26'h0, port_out}, {26'h0, pv});
      wr(j ? 8'h00 : 8'h04, j ? 32'h4 : 32'h9);
      repeat (20) @(posedge aclk);
      rd(8'h0C, {22'h0, 1'b1, !c[3], 3'h7, 4'h1, 1'b1, !j[0], 1'b0}, 34'hFFE);
    end
    $display("stop release done");
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h2);
    rd(8'h0C, 34'h140, 34'h178);
    repeat (20) @(posedge aclk);
    wr(8'h08, 32'h40);
    wr(8'h00, 32'h2);
    rd(8'h0C, 34'h9, 34'h79);
    $display("fallback and refusal done");
    summarize();
  end
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule
